/* bcd_decimal_float_divide_op_checker.sv */
`default_nettype none

module bcd_decimal_float_divide_op_checker (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Operands and trigger
    input wire bcd_decimal_float_divide_op_pkg::word_t dividendPairHi,
    input wire bcd_decimal_float_divide_op_pkg::word_t dividendPairLo,
    input wire bcd_decimal_float_divide_op_pkg::word_t divisorPairHi,
    input wire bcd_decimal_float_divide_op_pkg::word_t divisorPairLo,
    input wire logic opEnable,
    input wire logic edgeTrigger,
    // Results
    input wire bcd_decimal_float_divide_op_pkg::word_t resultPairHi,
    input wire bcd_decimal_float_divide_op_pkg::word_t resultPairLo,
    input wire logic errorFlag,
    input wire logic zeroFlag,
    input wire logic done,
    input wire logic busy
);
    timeunit 1ns;
    timeprecision 100ps;
    import bcd_decimal_float_divide_op_pkg::*;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////
    function automatic logic badBcd(input logic [31:0] w);
        badBcd = 1'b0;
        for (int i = 0; i < 7; i++) badBcd |= w[i*4+:4] > 4'h9;
    endfunction : badBcd
    // Own copy of the previous trigger level; reset to 0 so a high level at release counts as a rise
    logic enPrev_q;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) enPrev_q <= 1'b0;
        else enPrev_q <= opEnable;
    end
    wire logic take = !busy && opEnable && !(edgeTrigger && enPrev_q);
    wire logic [31:0] res = {resultPairHi, resultPairLo};
    wire logic badA = badBcd({dividendPairHi, dividendPairLo});
    wire logic badB = badBcd({divisorPairHi, divisorPairLo});
    wire logic zeroB = {divisorPairHi[11:0], divisorPairLo} == 28'h0;
    ////////////////////////////////////////////////////////////////
    done_pulse_a: assert property (done |=> !done)
        else $error("done wider than one cycle");
    result_hold_a: assert property (!done |-> $stable({res, errorFlag, zeroFlag}))
        else $error("result moved without done");
    answer_time_a: assert property (take |-> ##[2:73] done)
        else $error("no done in time");
    take_busy_a: assert property (take |=> busy)
        else $error("start not taken");
    bad_dividend_a: assert property (take && badA |-> ##2 done && errorFlag)
        else $error("bad dividend not flagged");
    bad_divisor_a: assert property (take && badB |-> ##2 done && errorFlag)
        else $error("bad divisor not flagged");
    zero_div_a: assert property (take && !badA && !badB && zeroB |-> ##2 done && errorFlag && res == 32'h0)
        else $error("zero divisor not flagged");
    zero_flag_a: assert property (done && !errorFlag |-> zeroFlag == (res == 32'h0))
        else $error("zero flag wrong");
    error_out_a: assert property (done && errorFlag |-> res == 32'h0 && !zeroFlag)
        else $error("error result not cleared");
    norm_out_a: assert property (done && !errorFlag && !zeroFlag |-> res[27:24] != 4'h0 && !badBcd(res))
        else $error("result not normalised");
    cover property (take && edgeTrigger);
    cover property (take && !edgeTrigger);
    cover property (done && errorFlag);
    cover property (done && zeroFlag);
endmodule : bcd_decimal_float_divide_op_checker

bind bcd_float_divider bcd_decimal_float_divide_op_checker bcd_decimal_float_divide_op_checker_inst (.clk_sys, .rst_n, .dividendPairHi,
    .dividendPairLo, .divisorPairHi, .divisorPairLo, .opEnable, .edgeTrigger, .resultPairHi,
    .resultPairLo, .errorFlag, .zeroFlag, .done, .busy);

`default_nettype wire

/* bcd_decimal_float_divide_op_pkg.sv */
`default_nettype none

package bcd_decimal_float_divide_op_pkg;
    typedef logic [15:0] word_t;
    typedef logic [3:0] bcdDigit_t;
    typedef logic signed [5:0] expVal_t;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_NORM,
        ST_DIVIDE,
        ST_FINISH
    } fdivState_t;
endpackage : bcd_decimal_float_divide_op_pkg

`default_nettype wire

/* bcd_decimal_float_divide_op_regs.svh */
`ifndef BCD_DECIMAL_FLOAT_DIVIDE_OP_REGS_SVH
`define BCD_DECIMAL_FLOAT_DIVIDE_OP_REGS_SVH

// Operand word layout: top digit is the exponent code, the seven below it the mantissa
`define FD_EXP_POS 28
`define FD_EXP_WIDTH 4
`define FD_MANT_MSB 27
`define FD_MANT_DIGITS 7
`define FD_DIGIT_LAST 3'h6

// Exponent codes 8..F carry a negative exponent 0..-7
`define FD_EXP_MAX 6'sh07
`define FD_EXP_MIN -6'sh07

// Magnitude limits as whole operand encodings
`define FD_MAX_VALUE 32'h79999999
`define FD_MIN_OPERAND 32'hF0000001
`define FD_MIN_RESULT 32'hF1000000

// Reset values of the held outputs
`define FD_RESULT_RST 32'h00000000
`define FD_FLAG_RST 1'b0

`endif

/* bcd_decimal_float_divide_op_seq_model.sv */
`default_nettype none

module bcd_decimal_float_divide_op_seq_model (
    // Clock and answer
    input wire logic clk_sys,
    input wire logic done,
    // Operands and trigger
    output bcd_decimal_float_divide_op_pkg::word_t dividendPairHi,
    output bcd_decimal_float_divide_op_pkg::word_t dividendPairLo,
    output bcd_decimal_float_divide_op_pkg::word_t divisorPairHi,
    output bcd_decimal_float_divide_op_pkg::word_t divisorPairLo,
    output logic opEnable,
    output logic edgeTrigger
);
    timeunit 1ns;
    timeprecision 100ps;
    import bcd_decimal_float_divide_op_pkg::*;
    initial {opEnable, edgeTrigger, dividendPairHi, dividendPairLo, divisorPairHi, divisorPairLo} = '0;
    ////////////////////////////////////////////////////////////////
    task automatic issue(input logic [31:0] a, b, input logic md, input int n, output logic hung);
        int c;
        hung = 1'b0;
        @(posedge clk_sys);
        #1;
        {dividendPairHi, dividendPairLo, divisorPairHi, divisorPairLo} = {a, b};
        edgeTrigger = md;
        opEnable = 1'b1;
        // Edge mode: operands change two clock edges after the trigger is raised, so a late operand sample shows up
        if (md) begin
            @(posedge clk_sys);
            @(posedge clk_sys);
            #1;
            {dividendPairHi, dividendPairLo, divisorPairHi, divisorPairLo} = ~{a, b};
        end
        repeat (n) begin
            for (c = 0; c < 100; c++) begin
                @(negedge clk_sys);
                if (done === 1'b1) break;
            end
            hung |= (c == 100);
        end
        // Held past done in edge mode: a second run would be a fault
        if (md) repeat (12) @(negedge clk_sys);
        @(posedge clk_sys);
        #1;
        opEnable = 1'b0;
        // Inverted after release so a late operand sample shows up
        {dividendPairHi, dividendPairLo, divisorPairHi, divisorPairLo} = ~{a, b};
    endtask : issue
endmodule : bcd_decimal_float_divide_op_seq_model

`default_nettype wire

/* bcd_float_divider.sv */
`include "bcd_decimal_float_divide_op_regs.svh"

`default_nettype none

module bcd_float_divider (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Operand pairs from the sequencer
    input wire bcd_decimal_float_divide_op_pkg::word_t dividendPairHi,
    input wire bcd_decimal_float_divide_op_pkg::word_t dividendPairLo,
    input wire bcd_decimal_float_divide_op_pkg::word_t divisorPairHi,
    input wire bcd_decimal_float_divide_op_pkg::word_t divisorPairLo,
    // Trigger
    input wire logic opEnable,
    input wire logic edgeTrigger,
    // Result pair and flags
    output bcd_decimal_float_divide_op_pkg::word_t resultPairHi,
    output bcd_decimal_float_divide_op_pkg::word_t resultPairLo,
    output logic errorFlag,
    output logic zeroFlag,
    // Status
    output logic done,
    output logic busy
);
    import bcd_decimal_float_divide_op_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Helper functions

    function automatic logic isBcd(input logic [27:0] m);
        logic ok;
        ok = 1'b1;
        for (int i = 0; i < `FD_MANT_DIGITS; i++) begin
            if (m[i*4 +: 4] > 4'h9) begin
                ok = 1'b0;
            end
        end
        return ok;
    endfunction : isBcd

    function automatic logic [23:0] bcdToBin(input logic [27:0] m);
        logic [23:0] acc;
        acc = 24'h000000;
        for (int i = `FD_MANT_DIGITS - 1; i >= 0; i--) begin
            acc = 24'(acc * 24'h00000A + {20'h00000, m[i*4 +: 4]});
        end
        return acc;
    endfunction : bcdToBin

    function automatic logic [2:0] leadZeros(input logic [27:0] m);
        logic [2:0] n;
        logic found;
        n = 3'h0;
        found = 1'b0;
        for (int i = `FD_MANT_DIGITS - 1; i >= 0; i--) begin
            if (!found && m[i*4 +: 4] == 4'h0) begin
                n = 3'(n + 3'h1);
            end else begin
                found = 1'b1;
            end
        end
        return n;
    endfunction : leadZeros

    function automatic logic [23:0] pow10(input logic [2:0] n);
        logic [23:0] p;
        unique case (n)
            3'h0: p = 24'h000001;
            3'h1: p = 24'h00000A;
            3'h2: p = 24'h000064;
            3'h3: p = 24'h0003E8;
            3'h4: p = 24'h002710;
            3'h5: p = 24'h0186A0;
            3'h6: p = 24'h0F4240;
            default: p = 24'h000001;
        endcase
        return p;
    endfunction : pow10

    function automatic expVal_t decodeExp(input logic [3:0] code);
        expVal_t mag;
        mag = $signed({3'b000, code[2:0]});
        return code[3] ? expVal_t'(-mag) : mag;
    endfunction : decodeExp

    ////////////////////////////////////////////////////////////////////////
    // State

    fdivState_t stateQ;
    fdivState_t stateD;
    logic [31:0] ddQ;
    logic [31:0] drQ;
    expVal_t expQ;
    logic [31:0] resultQ;
    logic errQ;
    logic zeroQ;
    logic enablePrevQ;

    ////////////////////////////////////////////////////////////////////////
    // Trigger: level mode reruns while enabled, edge mode fires once per rise

    wire logic enableRise = opEnable & ~enablePrevQ;
    wire logic startReq = edgeTrigger ? enableRise : opEnable;
    wire logic takeStart = (stateQ == ST_IDLE) && startReq;

    ////////////////////////////////////////////////////////////////////////
    // Operand decode

    wire logic [27:0] ddMant = ddQ[`FD_MANT_MSB:0];
    wire logic [27:0] drMant = drQ[`FD_MANT_MSB:0];
    wire expVal_t ddExp = decodeExp(ddQ[`FD_EXP_POS +: `FD_EXP_WIDTH]);
    wire expVal_t drExp = decodeExp(drQ[`FD_EXP_POS +: `FD_EXP_WIDTH]);

    // Operand validity is checked rather than assumed, so a bad word cannot reach the divider
    wire logic ddBad = !isBcd(ddMant);
    wire logic drBad = !isBcd(drMant);
    wire logic drZero = drMant == 28'h0000000;
    wire logic ddZero = ddMant == 28'h0000000;
    wire logic earlyErr = ddBad | drBad | drZero;

    ////////////////////////////////////////////////////////////////////////
    // Normalisation: shift both mantissas so the leading digit is non-zero

    wire logic [2:0] ddLead = leadZeros(ddMant);
    wire logic [2:0] drLead = leadZeros(drMant);
    wire logic [23:0] ddNorm = 24'(bcdToBin(ddMant) * pow10(ddLead));
    wire logic [23:0] drNorm = 24'(bcdToBin(drMant) * pow10(drLead));
    wire logic ddBelow = ddNorm < drNorm;

    // Ratio below one starts one decade down so the first digit is never zero
    wire logic [26:0] remInit = ddBelow ? 27'(ddNorm * 27'h000000A) : {3'b000, ddNorm};
    wire expVal_t expNorm = expVal_t'(ddExp - $signed({3'b000, ddLead})
        - drExp + $signed({3'b000, drLead}) + (ddBelow ? 6'sh00 : 6'sh01));

    ////////////////////////////////////////////////////////////////////////
    // Digit generator

    logic [27:0] quotDigits;
    logic stepDone;

    decimal_digit_stepper decimal_digit_stepper_inst (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .load(stateQ == ST_NORM && !earlyErr && !ddZero),
        .remInit(remInit),
        .divisor(drNorm),
        .digits(quotDigits),
        .done(stepDone)
    );

    ////////////////////////////////////////////////////////////////////////
    // Result packing and range check

    wire logic expHigh = expQ > `FD_EXP_MAX;
    wire logic expLow = expQ < `FD_EXP_MIN;
    wire expVal_t expMag = expQ[5] ? expVal_t'(-expQ) : expQ;
    wire logic [3:0] expCode = {expQ[5], expMag[2:0]};
    wire logic [31:0] quotWord = {expCode, quotDigits};

    ////////////////////////////////////////////////////////////////////////
    // Sequencer

    always_comb begin
        stateD = stateQ;
        unique case (stateQ)
            ST_IDLE: begin
                if (takeStart) begin
                    stateD = ST_NORM;
                end
            end
            ST_NORM: begin
                stateD = (earlyErr || ddZero) ? ST_FINISH : ST_DIVIDE;
            end
            ST_DIVIDE: begin
                if (stepDone) begin
                    stateD = ST_FINISH;
                end
            end
            ST_FINISH: begin
                stateD = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            stateQ <= ST_IDLE;
            enablePrevQ <= 1'b0;
        end else begin
            stateQ <= stateD;
            enablePrevQ <= opEnable;
        end
    end

    // Operands are captured on the start so the sequencer may change them mid-division
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ddQ <= 32'h00000000;
            drQ <= 32'h00000000;
        end else if (takeStart) begin
            ddQ <= {dividendPairHi, dividendPairLo};
            drQ <= {divisorPairHi, divisorPairLo};
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            expQ <= 6'sh00;
        end else if (stateQ == ST_NORM) begin
            expQ <= expNorm;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs change only at the end of an operation and hold until the next one

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            resultQ <= `FD_RESULT_RST;
            errQ <= `FD_FLAG_RST;
            zeroQ <= `FD_FLAG_RST;
        end else if (stateQ == ST_NORM && (earlyErr || ddZero)) begin
            resultQ <= `FD_RESULT_RST;
            errQ <= earlyErr;
            zeroQ <= !earlyErr;
        end else if (stateQ == ST_DIVIDE && stepDone) begin
            // An out-of-range quotient is not written; zero goes out instead
            resultQ <= (expHigh || expLow) ? `FD_RESULT_RST : quotWord;
            errQ <= expHigh || expLow;
            zeroQ <= 1'b0;
        end
    end

    assign resultPairHi = resultQ[31:16];
    assign resultPairLo = resultQ[15:0];
    assign errorFlag = errQ;
    assign zeroFlag = zeroQ;
    assign done = stateQ == ST_FINISH;
    assign busy = stateQ != ST_IDLE;
endmodule : bcd_float_divider

`default_nettype wire

/* decimal_digit_stepper.sv */
`include "bcd_decimal_float_divide_op_regs.svh"

`default_nettype none

module decimal_digit_stepper (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Load of a normalised division
    input wire logic load,
    input wire logic [26:0] remInit,
    input wire logic [23:0] divisor,
    // Quotient digits, most significant first
    output logic [27:0] digits,
    output logic done
);
    import bcd_decimal_float_divide_op_pkg::*;

    logic [26:0] remQ;
    logic [26:0] remD;
    bcdDigit_t curQ;
    logic [2:0] cntQ;
    logic [27:0] digitsQ;
    logic runQ;
    logic doneQ;

    wire logic canSub = remQ >= {3'b000, divisor};
    wire logic lastDigit = cntQ == `FD_DIGIT_LAST;

    ////////////////////////////////////////////////////////////////////////
    // One subtraction per cycle; the digit is closed when the remainder drops below the divisor
    assign remD = canSub ? 27'(remQ - {3'b000, divisor}) : 27'(remQ * 27'h000000A);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            remQ <= 27'h0000000;
            curQ <= 4'h0;
            cntQ <= 3'h0;
            digitsQ <= 28'h0000000;
            runQ <= 1'b0;
            doneQ <= 1'b0;
        end else if (load) begin
            remQ <= remInit;
            curQ <= 4'h0;
            cntQ <= 3'h0;
            runQ <= 1'b1;
            doneQ <= 1'b0;
        end else begin
            doneQ <= 1'b0;
            if (runQ) begin
                remQ <= remD;
                if (canSub) begin
                    curQ <= 4'(curQ + 4'h1);
                end else begin
                    // Remainder is dropped after the seventh digit: truncation, not rounding
                    digitsQ <= {digitsQ[23:0], curQ};
                    curQ <= 4'h0;
                    cntQ <= 3'(cntQ + 3'h1);
                    if (lastDigit) begin
                        runQ <= 1'b0;
                        doneQ <= 1'b1;
                    end
                end
            end
        end
    end

    assign digits = digitsQ;
    assign done = doneQ;
endmodule : decimal_digit_stepper

`default_nettype wire

/* tb_bcd_float_divider.sv */
`default_nettype none

module tb_bcd_float_divider;
    timeunit 1ns;
    timeprecision 100ps;
    import bcd_decimal_float_divide_op_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    word_t dividendPairHi, dividendPairLo, divisorPairHi, divisorPairLo, resultPairHi, resultPairLo;
    logic opEnable, edgeTrigger, errorFlag, zeroFlag, done, busy, hung;
    logic [33:0] expQ[$];
    logic [31:0] seed = 32'h08f2af04;
    logic [31:0] a, b;
    int n_mismatch = 0;
    int tests_run = 0;
    logic [63:0] dirv [12] = '{64'h40001234_40000002, 64'h61234567_11000000, 64'hB1234567_11000000,
        64'h12340000_30000000, 64'h400A0000_11000000, 64'h11000000_40000B00, 64'h00000000_11000000,
        64'h79999999_F1000000, 64'hF0000001_F0000001, 64'h11000000_13000000, 64'h85000000_12000000,
        64'hF1000000_11000000};
    always #5 clk_sys = ~clk_sys;
    ////////////////////////////////////////////////////////////////
    bcd_float_divider bcd_float_divider_inst (.clk_sys, .rst_n, .dividendPairHi, .dividendPairLo,
        .divisorPairHi, .divisorPairLo, .opEnable, .edgeTrigger, .resultPairHi, .resultPairLo,
        .errorFlag, .zeroFlag, .done, .busy);
    bcd_decimal_float_divide_op_seq_model bcd_decimal_float_divide_op_seq_model_inst (.clk_sys, .done, .dividendPairHi, .dividendPairLo,
        .divisorPairHi, .divisorPairLo, .opEnable, .edgeTrigger);
    ////////////////////////////////////////////////////////////////
    function automatic logic [33:0] ref_div(input logic [31:0] x, y);
        longint ma, mb, q;
        int ea, eb, e, i;
        logic bad;
        logic [31:0] r;
        bad = 1'b0;
        ma = 0;
        mb = 0;
        for (i = 6; i >= 0; i--) begin
            bad |= (x[i*4+:4] > 9) || (y[i*4+:4] > 9);
            ma = ma * 10 + x[i*4+:4];
            mb = mb * 10 + y[i*4+:4];
        end
        ea = x[31] ? -int'(x[30:28]) : int'(x[30:28]);
        eb = y[31] ? -int'(y[30:28]) : int'(y[30:28]);
        if (bad || mb == 0) return {2'b10, 32'h0};
        if (ma == 0) return {2'b01, 32'h0};
        while (ma < 1000000) begin
            ma *= 10;
            ea--;
        end
        while (mb < 1000000) begin
            mb *= 10;
            eb--;
        end
        e = ea - eb;
        // Integer division gives truncation, never rounding
        if (ma >= mb) begin
            q = ma * 1000000 / mb;
            e++;
        end else q = ma * 10000000 / mb;
        if (e > 7 || e < -7) return {2'b10, 32'h0};
        r[31:28] = 4'(e < 0 ? 8 - e : e);
        for (i = 0; i < 7; i++) begin
            r[i*4+:4] = 4'(q % 10);
            q /= 10;
        end
        return {2'b00, r};
    endfunction : ref_div

    function automatic logic [31:0] rnd_op();
        logic [31:0] w;
        w[31:28] = 4'($random(seed));
        for (int i = 0; i < 7; i++) w[i*4+:4] = 4'({$random(seed)} % 10);
        return w;
    endfunction : rnd_op

    task automatic chk(input logic [33:0] e, g);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %0t exp %h got %h", $time, e, g);
        end
    endtask : chk

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : wrap_up

    task automatic run(input logic [31:0] x, y, input logic md, input int n);
        repeat (n) expQ.push_back(ref_div(x, y));
        bcd_decimal_float_divide_op_seq_model_inst.issue(x, y, md, n, hung);
        if (hung) begin
            n_mismatch++;
            wrap_up();
        end
    endtask : run
    ////////////////////////////////////////////////////////////////
    always @(negedge clk_sys) begin
        if (rst_n && done === 1'b1)
            chk(expQ.size() ? expQ.pop_front() : 'x, {errorFlag, zeroFlag, resultPairHi, resultPairLo});
    end

    initial begin
        repeat (8) @(posedge clk_sys);
        chk(34'h0, {errorFlag | busy | done, zeroFlag, resultPairHi, resultPairLo});
        #1 rst_n = 1'b1;
        for (int i = 0; i < 12; i++) run(dirv[i][63:32], dirv[i][31:0], 1'b1, 1);
        // Odd passes use the edge trigger, even ones the level trigger with two runs
        for (int i = 0; i < 40; i++) begin
            a = rnd_op();
            b = rnd_op();
            run(a, b, i[0], i[0] ? 1 : 2);
        end
        chk(34'h0, 34'(expQ.size()));
        wrap_up();
    end
endmodule : tb_bcd_float_divider

`default_nettype wire
